// ### rtl/qps_map.svh
`ifndef QPS_MAP_SVH
`define QPS_MAP_SVH

// Register byte offsets on the AXI4-Lite window
`define QPS_CTRL_OFS     8'h00
`define QPS_STAT_OFS     8'h04
`define QPS_CNT_BASE     8'h10
`define QPS_MASK_BASE    8'h20

// Field positions and reset values
`define QPS_CTRL_MBX_EN  0
`define QPS_CTRL_RST     1'h1
`define QPS_CNT_RST      16'h0000

// Write and read responses
`define QPS_RESP_OKAY    2'h0
`define QPS_RESP_SLVERR  2'h2

`endif

// ### rtl/qps_pkg.sv
package qps_pkg;

    // Registered controls of one memory port, all but oe_n sampled on the rising edge
    typedef struct packed {
        logic cs_low_n;
        logic cs_high;
        logic rw;
        logic oe_n;
        logic lb_n;
        logic ub_n;
        logic counter_load_n;
        logic counter_increment_n;
        logic counter_clear_n;
        logic counter_readback_n;
        logic mask_capture_n;
        logic mask_readback_n;
    } qps_ctl_t;

    // Per-port status as collected for software
    typedef struct packed {
        logic [3:0] power_down;
        logic [3:0] wrap;
        logic [3:0] mailbox;
    } qps_status_t;

endpackage

// ### rtl/qps_top.sv
`timescale 1ns/100ps
`include "qps_map.svh"
module qps_top #(
    parameter int ADDR_W = 16
) (
    // System
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic                           global_init_n,
    // Memory ports
    input  wire qps_pkg::qps_ctl_t [3:0]        port_ctl,
    input  wire logic [3:0][ADDR_W-1:0]         addr_in,
    output logic      [3:0][ADDR_W-1:0]         addr_out,
    output logic      [3:0]                     addr_oe,
    input  wire logic [3:0][17:0]               data_in,
    output logic      [3:0][17:0]               data_out,
    output logic      [3:0][1:0]                data_oe,
    output logic      [3:0]                     counter_wrap_irq_n,
    output logic      [3:0]                     mailbox_irq_n,
    // AXI4-Lite write
    input  wire logic [7:0]                     s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]                     s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready
);
    import qps_pkg::*;

    localparam int NP    = 4;
    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W < 3 || ADDR_W > 16) begin : g_chk
        $error("qps_top: ADDR_W must lie between 3 and 16");
    end

    function automatic logic [ADDR_W-1:0] mbx_addr(input int q);
        mbx_addr = {ADDR_W{1'b1}} - ADDR_W'(q);
    endfunction

    function automatic logic [ADDR_W-1:0] wrapped_inc(input logic [ADDR_W-1:0] c,
                                                    input logic [ADDR_W-1:0] m);
        wrapped_inc = (c & ~m) | (ADDR_W'(c + 1'b1) & m);
    endfunction

    function automatic logic wrap_hit(input logic [ADDR_W-1:0] c,
                                      input logic [ADDR_W-1:0] m);
        wrap_hit = (c & m) == m;
    endfunction

    // Master reset joins the bus reset; both act on the clock edge
    logic                         rst;
    logic [17:0]                  mem [DEPTH];
    logic [NP-1:0][ADDR_W-1:0]    cnt_reg;
    logic [NP-1:0][ADDR_W-1:0]    mask_reg;
    logic [NP-1:0][ADDR_W-1:0]    eff_addr;
    logic [NP-1:0]                sel;
    logic [NP-1:0]                write_en;
    logic [NP-1:0]                read_en;
    logic [NP-1:0]                inc_wrap;
    logic [NP-1:0]                wrap_reg;
    logic [NP-1:0]                pwr_down_reg;
    logic [NP-1:0]                out_en_reg;
    logic [NP-1:0][1:0]           byte_en_reg;
    logic [NP-1:0][17:0]          rd_data_reg;
    logic [NP-1:0][ADDR_W-1:0]    addr_out_reg;
    logic [NP-1:0]                addr_oe_reg;
    logic [NP-1:0]                mbx_set;
    logic [NP-1:0]                mbx_clr;
    logic [NP-1:0]                mbx_flag_reg;
    logic                         mbx_en_reg;
    qps_status_t                  status;

    assign rst = !aresetn || !global_init_n;

    // Address selection per port
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            sel[p]      = !port_ctl[p].cs_low_n && port_ctl[p].cs_high;
            write_en[p] = sel[p] && !port_ctl[p].rw;
            read_en[p]  = sel[p] && port_ctl[p].rw;
            inc_wrap[p] = port_ctl[p].counter_clear_n && port_ctl[p].counter_load_n
                          && !port_ctl[p].counter_increment_n
                          && wrap_hit(cnt_reg[p], mask_reg[p]);
            if (!port_ctl[p].counter_clear_n) begin
                eff_addr[p] = '0;
            end else if (!port_ctl[p].counter_load_n) begin
                eff_addr[p] = addr_in[p];
            end else if (!port_ctl[p].counter_increment_n) begin
                eff_addr[p] = wrapped_inc(cnt_reg[p], mask_reg[p]);
            end else begin
                eff_addr[p] = cnt_reg[p];
            end
        end
    end

    // Counters and masks; each port's state depends only on its own pins
    always_ff @(posedge aclk) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) begin
                cnt_reg[p]  <= ADDR_W'(`QPS_CNT_RST);
                mask_reg[p] <= '1;
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                cnt_reg[p] <= eff_addr[p];
                if (!port_ctl[p].mask_capture_n) begin
                    mask_reg[p] <= addr_in[p];
                end
            end
        end
    end

    // Wrap pulse lasts one cycle because it is recomputed every edge
    always_ff @(posedge aclk) begin
        if (rst) begin
            wrap_reg <= '0;
        end else begin
            wrap_reg <= inc_wrap;
        end
    end

    assign counter_wrap_irq_n = ~wrap_reg;

    // Array write; lower index loses when two ports hit one word
    always_ff @(posedge aclk) begin
        for (int p = 0; p < NP; p++) begin
            if (write_en[p] && !rst) begin
                if (!port_ctl[p].lb_n) begin
                    mem[eff_addr[p]][8:0] <= data_in[p][8:0];
                end
                if (!port_ctl[p].ub_n) begin
                    mem[eff_addr[p]][17:9] <= data_in[p][17:9];
                end
            end
        end
    end

    // Read pipeline; every port may read any word in the same cycle
    always_ff @(posedge aclk) begin
        if (rst) begin
            rd_data_reg  <= '0;
            out_en_reg   <= '0;
            byte_en_reg  <= '0;
            pwr_down_reg <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (read_en[p]) begin
                    rd_data_reg[p] <= mem[eff_addr[p]];
                end
                out_en_reg[p]   <= read_en[p];
                byte_en_reg[p]  <= {!port_ctl[p].ub_n, !port_ctl[p].lb_n}
                                   & {2{read_en[p]}};
                pwr_down_reg[p] <= !sel[p];
            end
        end
    end

    // Output enable stays asynchronous, like the pin it models
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            data_oe[p] = byte_en_reg[p] & {2{out_en_reg[p] && !port_ctl[p].oe_n}};
        end
    end

    assign data_out = rd_data_reg;

    // Readback drives the address lines for one cycle after the request
    always_ff @(posedge aclk) begin
        if (rst) begin
            addr_out_reg <= '0;
            addr_oe_reg  <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                addr_oe_reg[p]  <= !port_ctl[p].counter_readback_n
                                   || !port_ctl[p].mask_readback_n;
                addr_out_reg[p] <= !port_ctl[p].counter_readback_n
                                   ? cnt_reg[p] : mask_reg[p];
            end
        end
    end

    assign addr_out = addr_out_reg;
    assign addr_oe  = addr_oe_reg;

    // Mailbox decode ignores output enable and byte enables
    always_comb begin
        for (int q = 0; q < NP; q++) begin
            mbx_set[q] = 1'b0;
            for (int p = 0; p < NP; p++) begin
                if (p != q && write_en[p] && eff_addr[p] == mbx_addr(q)) begin
                    mbx_set[q] = mbx_en_reg;
                end
            end
            mbx_clr[q] = read_en[q] && eff_addr[q] == mbx_addr(q);
        end
    end

    // A set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (rst) begin
            mbx_flag_reg <= '0;
        end else begin
            for (int q = 0; q < NP; q++) begin
                if (mbx_set[q]) begin
                    mbx_flag_reg[q] <= 1'b1;
                end else if (mbx_clr[q]) begin
                    mbx_flag_reg[q] <= 1'b0;
                end
            end
        end
    end

    assign mailbox_irq_n = ~mbx_flag_reg;

    // AXI4-Lite slave: address and data held independently until both arrive
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rd_idx;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign status        = '{power_down: pwr_down_reg, wrap: wrap_reg, mailbox: mbx_flag_reg};
    assign rd_idx        = s_axi_araddr[3:2];

    always_ff @(posedge aclk) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `QPS_RESP_OKAY;
            mbx_en_reg  <= `QPS_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_hold_reg && w_hold_reg) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                if (aw_addr_reg == `QPS_CTRL_OFS) begin
                    bresp_reg <= `QPS_RESP_OKAY;
                    if (w_strb_reg[0]) begin
                        mbx_en_reg <= w_data_reg[`QPS_CTRL_MBX_EN];
                    end
                end else begin
                    bresp_reg <= `QPS_RESP_SLVERR;
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `QPS_RESP_OKAY;
            rdata_reg  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `QPS_RESP_OKAY;
            rdata_reg  <= '0;
            if (s_axi_araddr == `QPS_CTRL_OFS) begin
                rdata_reg[`QPS_CTRL_MBX_EN] <= mbx_en_reg;
            end else if (s_axi_araddr == `QPS_STAT_OFS) begin
                rdata_reg[$bits(status)-1:0] <= status;
            end else if ({s_axi_araddr[7:4], 4'h0} == `QPS_CNT_BASE
                         && s_axi_araddr[1:0] == 2'h0) begin
                rdata_reg[ADDR_W-1:0] <= cnt_reg[rd_idx];
            end else if ({s_axi_araddr[7:4], 4'h0} == `QPS_MASK_BASE
                         && s_axi_araddr[1:0] == 2'h0) begin
                rdata_reg[ADDR_W-1:0] <= mask_reg[rd_idx];
            end else begin
                rresp_reg <= `QPS_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Checks on port 0 and the mailbox of port 0
    default clocking cb @(posedge aclk); endclocking
    default disable iff (rst);

    sequence s_p1_writes_mbx0;
        mbx_en_reg && write_en[1] && eff_addr[1] == mbx_addr(0);
    endsequence

    sequence s_p0_reads_own_mbx;
        read_en[0] && eff_addr[0] == mbx_addr(0) && !mbx_set[0];
    endsequence

    property p_load_addr;
        port_ctl[0].counter_clear_n && !port_ctl[0].counter_load_n
        |=> cnt_reg[0] == $past(addr_in[0]);
    endproperty
    a_load_addr: assert property (p_load_addr) else $error("load not captured");

    property p_hold;
        port_ctl[0].counter_clear_n && port_ctl[0].counter_load_n
        && port_ctl[0].counter_increment_n
        |=> cnt_reg[0] == $past(cnt_reg[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved on hold");

    property p_inc;
        port_ctl[0].counter_clear_n && port_ctl[0].counter_load_n
        && !port_ctl[0].counter_increment_n && mask_reg[0] == '1
        |=> cnt_reg[0] == ADDR_W'($past(cnt_reg[0]) + 1'b1);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_clear;
        !port_ctl[0].counter_clear_n |-> eff_addr[0] == '0 ##1 cnt_reg[0] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not at zero");

    property p_wrap_pulse;
        !counter_wrap_irq_n[0] |-> $past(inc_wrap[0]) && cnt_reg[0] == (cnt_reg[0] & ~mask_reg[0]);
    endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse unexplained");

    property p_mbx_set;
        s_p1_writes_mbx0 |=> !mailbox_irq_n[0];
    endproperty
    a_mbx_set: assert property (p_mbx_set) else $error("mailbox not set");

    property p_mbx_clear;
        s_p0_reads_own_mbx |=> mailbox_irq_n[0];
    endproperty
    a_mbx_clear: assert property (p_mbx_clear) else $error("mailbox not cleared");

    property p_self_write;
        mailbox_irq_n[0] && !mbx_set[0] |=> mailbox_irq_n[0];
    endproperty
    a_self_write: assert property (p_self_write) else $error("own write raised flag");

    property p_pipe_out;
        data_oe[0] != 2'h0 |-> $past(read_en[0]) && !port_ctl[0].oe_n;
    endproperty
    a_pipe_out: assert property (p_pipe_out) else $error("output without read");

    property p_powerdown;
        !sel[0] |=> pwr_down_reg[0] && data_oe[0] == 2'h0;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("deselect not honoured");

    property p_readback;
        !port_ctl[0].counter_readback_n |=> addr_oe[0] && addr_out[0] == $past(cnt_reg[0]);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

endmodule

// ### sim/qps_host.sv
`timescale 1ns/100ps
module qps_host (
    // Clock
    input  wire logic                   aclk,
    // Address lines as seen from the device
    input  wire logic [3:0][15:0]       addr_out,
    input  wire logic [3:0]             addr_oe,
    // Host drive
    output qps_pkg::qps_ctl_t [3:0]     port_ctl,
    output logic [3:0][15:0]            addr_in,
    output logic [3:0][17:0]            data_in
);
    import qps_pkg::*;
    localparam qps_ctl_t IDLE = 12'haff;
    logic [3:0][15:0] adr;
    logic [3:0]       drv;
    // A released bus shows the inverse of its last value, so a stale address never matches
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            addr_in[p] = addr_oe[p] ? addr_out[p] : (drv[p] ? adr[p] : ~adr[p]);
        end
    end
    initial begin
        port_ctl = {4{IDLE}};
        adr = '0;
        drv = '0;
        data_in = '0;
    end
    // Callers never write one address from two ports in the same cycle
    task automatic set(input int p, input qps_ctl_t c, input logic [15:0] a,
                       input logic [17:0] d);
        port_ctl[p] <= c;
        adr[p] <= a;
        drv[p] <= 1'b1;
        data_in[p] <= d;
    endtask
    // Idle deselects and lets go of the address lines; nothing is left to rewrite
    task automatic idle();
        port_ctl <= {4{IDLE}};
        drv <= '0;
    endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/100ps
`include "qps_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    import qps_pkg::*;
    typedef struct packed {logic [1:0] p; logic rd; logic [15:0] a; logic [17:0] d;} qps_row_t;
    localparam qps_ctl_t RD = 12'h61f, WR = 12'h51f, RINC = 12'h62f, RHLD = 12'h63f,
        WINC = 12'h52f, WCLR = 12'h537, RCLR = 12'h637, MCAP = 12'h63d, CRB = 12'h63b,
        MRB = 12'h63e, WNB = 12'h5df, RNB = 12'h7df;
    logic                   aclk = 0, aresetn = 0, global_init_n = 1;
    qps_ctl_t [3:0]         port_ctl;
    logic [3:0][15:0]       addr_in, addr_out;
    logic [3:0][17:0]       data_in, data_out;
    logic [3:0][1:0]        data_oe;
    logic [3:0]             addr_oe, counter_wrap_irq_n, mailbox_irq_n;
    logic [7:0]             s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]            s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [3:0]             s_axi_wstrb = 4'hf;
    logic                   s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                   s_axi_arvalid = 0, s_axi_rready = 0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]             s_axi_bresp, s_axi_rresp, rsp;
    int                     num_errors = 0, samples_checked = 0, w;
    // Every read comes at least one edge after the write it expects
    qps_row_t rows [6] = '{'{0, 0, 16'h0010, 18'h2a5a5}, '{1, 0, 16'h0011, 18'h15a5a},
        '{2, 1, 16'h0010, 18'h2a5a5}, '{3, 1, 16'h0011, 18'h15a5a},
        '{1, 0, 16'hfffb, 18'h00001}, '{0, 1, 16'hfffb, 18'h00001}};
    always #5 aclk = ~aclk;
    qps_host host_u (.aclk(aclk), .addr_out(addr_out), .addr_oe(addr_oe),
        .port_ctl(port_ctl), .addr_in(addr_in), .data_in(data_in));
    qps_top #(.ADDR_W(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .global_init_n(global_init_n), .port_ctl(port_ctl), .addr_in(addr_in),
        .addr_out(addr_out), .addr_oe(addr_oe), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .counter_wrap_irq_n(counter_wrap_irq_n),
        .mailbox_irq_n(mailbox_irq_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic op(input int p, input qps_ctl_t k, input logic [15:0] a, input logic [17:0] d);
        @(posedge aclk);
        host_u.set(p, k, a, d);
    endtask
    // Idle cycle, then look at what the previous request produced
    task automatic fin();
        @(posedge aclk);
        host_u.idle();
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // Whole plan is well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        #1;
        `CHK({counter_wrap_irq_n, mailbox_irq_n, addr_oe, data_oe}, 20'hff000)
        op(0, MRB, 0, 0);
        fin();
        `CHK({addr_oe[0], addr_out[0]}, 17'h1ffff)
        op(0, CRB, 0, 0);
        fin();
        `CHK(addr_out[0], 16'h0000)
        note("reset");
        foreach (rows[i]) begin
            op(rows[i].p, rows[i].rd ? RD : WR, rows[i].a, rows[i].d);
            fin();
            if (rows[i].rd) `CHK({data_oe[rows[i].p], data_out[rows[i].p]}, {2'b11, rows[i].d})
        end
        note("rows");
        @(posedge aclk);
        for (int p = 0; p < 4; p++) host_u.set(p, RD, 16'h0010, 0);
        fin();
        for (int p = 0; p < 4; p++) `CHK(data_out[p], 18'h2a5a5)
        op(0, RD, 16'h0010, 0);
        op(0, RINC, 0, 0);
        op(0, RHLD, 0, 0);
        #1;
        `CHK(data_out[0], 18'h15a5a)
        fin();
        `CHK(data_out[0], 18'h15a5a)
        op(0, WINC, 0, 18'h0abcd);
        op(2, RD, 16'h0012, 0);
        fin();
        `CHK(data_out[2], 18'h0abcd)
        op(0, WCLR, 16'h0040, 18'h31234);
        op(1, RCLR, 16'h0040, 0);
        fin();
        `CHK(data_out[1], 18'h31234)
        note("counter");
        op(1, MCAP, 16'h0003, 0);
        op(1, RD, 16'h0002, 0);
        op(1, RINC, 0, 0);
        op(1, RINC, 0, 0);
        #1;
        `CHK(counter_wrap_irq_n, 4'hf)
        fin();
        `CHK(counter_wrap_irq_n, 4'hd)
        fin();
        `CHK(counter_wrap_irq_n, 4'hf)
        op(1, CRB, 0, 0);
        fin();
        `CHK({addr_oe[1], addr_out[1]}, 17'h10000)
        op(1, MRB, 0, 0);
        fin();
        `CHK({addr_oe[1], addr_out[1]}, 17'h10003)
        fin();
        `CHK(addr_oe[1], 1'b0)
        note("wrap");
        for (int q = 0; q < 4; q++) begin
            w = (q + 1) % 4;
            op(w, WNB, 16'hffff - q[15:0], 0);
            fin();
            `CHK(mailbox_irq_n, ~(4'h1 << q))
            op(q, WNB, 16'hffff - q[15:0], 0);
            fin();
            `CHK(mailbox_irq_n, ~(4'h1 << q))
            op(q, RNB, 16'hffff - q[15:0], 0);
            fin();
            `CHK(mailbox_irq_n, 4'hf)
        end
        note("mailbox");
        for (int k = 0; k < 2; k++) begin
            c_sel(k);
        end
        op(3, RD, 16'h0010, 0);
        fin();
        `CHK(data_oe[3], 2'b11)
        note("power down");
        axi_wr(`QPS_CTRL_OFS, 0, `QPS_RESP_OKAY);
        op(0, WNB, 16'hfffe, 0);
        fin();
        `CHK(mailbox_irq_n, 4'hf)
        axi_rd(`QPS_CTRL_OFS, rdat, rsp);
        `CHK({rsp, rdat}, {`QPS_RESP_OKAY, 32'h0})
        axi_wr(`QPS_CTRL_OFS, 1, `QPS_RESP_OKAY);
        axi_wr(8'h40, 32'h1, `QPS_RESP_SLVERR);
        axi_rd(8'h44, rdat, rsp);
        `CHK({rsp, rdat}, {`QPS_RESP_SLVERR, 32'h0})
        axi_rd(`QPS_MASK_BASE + 8'h04, rdat, rsp);
        `CHK(rdat, 32'h3)
        op(0, WNB, 16'hfffe, 0);
        fin();
        `CHK(mailbox_irq_n, 4'hd)
        @(posedge aclk);
        global_init_n <= 0;
        @(posedge aclk);
        global_init_n <= 1;
        #1;
        `CHK({mailbox_irq_n, counter_wrap_irq_n, addr_oe}, 12'hff0)
        axi_rd(`QPS_MASK_BASE + 8'h04, rdat, rsp);
        `CHK(rdat, 32'h0000ffff)
        note("bus and master reset");
        summarize();
    end
    // Either chip select alone deselects the port for one read cycle
    task automatic c_sel(input int k);
        qps_ctl_t c;
        c = RD;
        if (k == 0) c.cs_low_n = 1'b1;
        else c.cs_high = 1'b0;
        op(3, c, 16'h0010, 0);
        fin();
        `CHK(data_oe[3], 2'b00)
    endtask
endmodule
